// *** verilog/daoc_pkg.sv ***
/*
 * constants, register map and types for the dual converter output control.
 * assumes a 100 MHz MCLK and a 32-bit AXI4-Lite register port.
 */
`default_nettype none

package daoc_pkg;
    // ------------------------------------------------------------
    // word and bus sizes
    // ------------------------------------------------------------
    localparam int WORD_W = 12;  // converter word width
    localparam int PAIR_W = 2 * WORD_W;  // one sample pair, a over b
    localparam int ADDR_W = 4;  // register address width
    localparam int DATA_W = 32;  // register data width
    localparam int BUF_DEPTH = 2;  // entries of the sample buffer

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;  // control, read/write
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 4'h4;  // status, read only
    localparam logic [ADDR_W-1:0] COUNT_ADDR = 4'h8;  // emitted pairs, read only

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    localparam int CTRL_W = 6;
    localparam int CTRL_DIS_A = 0;  // out_disable_chan_a
    localparam int CTRL_DIS_B = 1;  // out_disable_chan_b
    localparam int CTRL_PD = 2;  // power_down_request
    localparam int CTRL_FMT_LO = 3;  // format_stabilizer_select, two bits
    localparam int CTRL_FMT_HI = 4;
    localparam int CTRL_MUX = 5;  // shared bus mode
    localparam logic [CTRL_W-1:0] CTRL_RESET = 6'h18;  // selector floating

    // ------------------------------------------------------------
    // status fields
    // ------------------------------------------------------------
    localparam int STAT_PD = 0;
    localparam int STAT_RECOVER = 1;
    localparam int STAT_SETTLE = 2;
    localparam int STAT_STAB = 3;
    localparam int STAT_TWOS = 4;

    // ------------------------------------------------------------
    // axi responses
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;  // MCLK rate
    localparam int PD_EXIT_US = 500;  // reference recharge after power-down
    localparam int PD_EXIT_CYCLES = PD_EXIT_US * CLK_MHZ;
    localparam int RECOVER_W = 17;  // counter width for the recharge time
    localparam int FMT_SETTLE_CYCLES = 4;  // MCLK cycles of suspect data after a selector change
    localparam int SETTLE_W = 3;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    // four selector levels, in the order of their field value
    typedef enum logic [1:0] {FMT_GROUND, FMT_SUPPLY, FMT_MIDREF, FMT_FLOAT} daoc_fmt_e;
    // output sequencer: a pair, or the pending b half on the shared bus
    typedef enum logic {OST_PAIR, OST_B} daoc_ost_e;
endpackage : daoc_pkg

`default_nettype wire

// *** verilog/daoc_fifo2.sv ***
/*
 * small valid/ready buffer for sample pairs, with a synchronous flush.
 * assumes one clock and a synchronous active-high reset.
 */
`default_nettype none

module daoc_fifo2 #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 2
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    // ------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [WIDTH-1:0] mem_reg [DEPTH];  // entries
    logic [AW-1:0] wr_ptr_reg;  // next write slot
    logic [AW-1:0] rd_ptr_reg;  // oldest entry
    logic [AW:0] count_reg;  // entries held
    logic [AW:0] count_next;
    logic in_ready_reg;  // registered room flag

    wire push = in_valid & in_ready_reg & ~flush;
    wire pop = out_valid & out_ready & ~flush;
    wire [AW-1:0] wr_ptr_inc = (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'b1;
    wire [AW-1:0] rd_ptr_inc = (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'b1;

    assign count_next = flush ? '0 : count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    assign in_ready = in_ready_reg;
    assign out_valid = (count_reg != '0);
    assign out_data = mem_reg[rd_ptr_reg];

    // pointers, fill level and room flag
    always_ff @(posedge clk) begin
        if (srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
            in_ready_reg <= 1'b1;
        end else begin
            wr_ptr_reg <= flush ? '0 : (push ? wr_ptr_inc : wr_ptr_reg);
            rd_ptr_reg <= flush ? '0 : (pop ? rd_ptr_inc : rd_ptr_reg);
            count_reg <= count_next;
            in_ready_reg <= (count_next != FULL);
        end
    end

    // one write port per entry
    genvar gi;
    generate
        for (gi = 0; gi < DEPTH; gi++) begin : g_entry
            always_ff @(posedge clk) begin
                if (push && wr_ptr_reg == AW'(gi)) begin
                    mem_reg[gi] <= in_data;
                end
            end
        end
    endgenerate
endmodule : daoc_fifo2

`default_nettype wire

// *** verilog/daoc_top.sv ***
/*
 * digital output control of a dual 12-bit converter: output enables,
 * power-down, format/stabilizer selector, separate or shared output bus,
 * with control and status over an AXI4-Lite slave.
 * assumes converter words arrive as offset-binary pairs on a valid/ready
 * stream in the MCLK domain, and the pads resolve data from data and enable.
 */
`default_nettype none

module daoc_top #(
    parameter int PD_EXIT_CYCLES = daoc_pkg::PD_EXIT_CYCLES
) (
    input wire logic MCLK,
    input wire logic SRST,
    // axi4-lite register port
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [daoc_pkg::ADDR_W-1:0] AWADDR,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [daoc_pkg::DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [daoc_pkg::ADDR_W-1:0] ARADDR,
    output logic RVALID,
    input wire logic RREADY,
    output logic [daoc_pkg::DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    // converter core sample stream
    input wire logic SAMPLE_VALID,
    output logic SAMPLE_READY,
    input wire logic [daoc_pkg::WORD_W-1:0] SAMPLE_A,
    input wire logic [daoc_pkg::WORD_W-1:0] SAMPLE_B,
    // output pins
    output logic [daoc_pkg::WORD_W-1:0] CHAN_A_SHARED_BUS,
    output logic CHAN_A_OE,
    output logic [daoc_pkg::WORD_W-1:0] CHAN_B_BUS,
    output logic CHAN_B_OE,
    // analog side controls and receiver hint
    output logic POWER_DOWN,
    output logic STABILIZER_ON,
    output logic DATA_SUSPECT
);
    // ------------------------------------------------------------
    // control register and its fields
    // ------------------------------------------------------------
    logic [daoc_pkg::CTRL_W-1:0] ctrl_reg;  // software control
    logic [daoc_pkg::CTRL_W-1:0] ctrl_next;  // after a write
    wire out_disable_chan_a = ctrl_reg[daoc_pkg::CTRL_DIS_A];
    wire out_disable_chan_b = ctrl_reg[daoc_pkg::CTRL_DIS_B];
    wire power_down_request = ctrl_reg[daoc_pkg::CTRL_PD];
    wire mux_mode = ctrl_reg[daoc_pkg::CTRL_MUX];
    wire [1:0] fmt_field = ctrl_reg[daoc_pkg::CTRL_FMT_HI:daoc_pkg::CTRL_FMT_LO];
    daoc_pkg::daoc_fmt_e format_stabilizer_select;

    // ------------------------------------------------------------
    // selector decode
    // ------------------------------------------------------------
    assign format_stabilizer_select = daoc_pkg::daoc_fmt_e'(fmt_field);
    // two's complement for ground and mid-reference levels
    wire twos_mode = (format_stabilizer_select == daoc_pkg::FMT_GROUND)
        | (format_stabilizer_select == daoc_pkg::FMT_MIDREF);
    // stabilizer for supply and ground levels
    wire stab_mode = (format_stabilizer_select == daoc_pkg::FMT_SUPPLY)
        | (format_stabilizer_select == daoc_pkg::FMT_GROUND);

    // ------------------------------------------------------------
    // recovery and settle counters
    // ------------------------------------------------------------
    logic [daoc_pkg::RECOVER_W-1:0] recover_cnt_reg;  // recharge time left
    logic [daoc_pkg::SETTLE_W-1:0] settle_cnt_reg;  // selector settle left
    wire recovering = (recover_cnt_reg != '0);
    wire settling = (settle_cnt_reg != '0);

    // ------------------------------------------------------------
    // axi write path
    // ------------------------------------------------------------
    logic awready_reg;  // address slot free
    logic wready_reg;  // data slot free
    logic bvalid_reg;  // write answer pending
    logic [1:0] bresp_reg;
    logic [daoc_pkg::ADDR_W-1:0] waddr_reg;  // held write address
    logic [daoc_pkg::DATA_W-1:0] wdata_reg;  // held write data
    logic [3:0] wstrb_reg;  // held byte enables
    wire aw_take = AWVALID & awready_reg;
    wire w_take = WVALID & wready_reg;
    // both halves held, no answer outstanding
    wire wr_do = ~awready_reg & ~wready_reg & ~bvalid_reg;
    wire wr_ctrl = wr_do & (waddr_reg == daoc_pkg::CTRL_ADDR);
    wire wr_known = wr_ctrl | (waddr_reg == daoc_pkg::STATUS_ADDR)
        | (waddr_reg == daoc_pkg::COUNT_ADDR);
    wire fmt_changed = wr_ctrl && wstrb_reg[0]
        && (ctrl_next[daoc_pkg::CTRL_FMT_HI:daoc_pkg::CTRL_FMT_LO] != fmt_field);

    assign ctrl_next = wstrb_reg[0] ? wdata_reg[daoc_pkg::CTRL_W-1:0] : ctrl_reg;

    // address/data capture in either order, then one answer
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= daoc_pkg::RESP_OKAY;
            waddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (aw_take) begin
                awready_reg <= 1'b0;
                waddr_reg <= AWADDR;
            end
            if (w_take) begin
                wready_reg <= 1'b0;
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end
            if (wr_do) begin
                // unmapped address answers slverr
                bvalid_reg <= 1'b1;
                bresp_reg <= wr_known ? daoc_pkg::RESP_OKAY : daoc_pkg::RESP_SLVERR;
            end else if (bvalid_reg && BREADY) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // control register update
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            ctrl_reg <= daoc_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= ctrl_next;
        end
    end

    // ------------------------------------------------------------
    // axi read path
    // ------------------------------------------------------------
    logic arready_reg;
    logic rvalid_reg;
    logic [daoc_pkg::DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [daoc_pkg::DATA_W-1:0] pair_count_reg;  // pairs sent to the pins
    wire ar_take = ARVALID & arready_reg;
    wire [daoc_pkg::DATA_W-1:0] status_word = {
        {(daoc_pkg::DATA_W - 5){1'b0}}, twos_mode, stab_mode,
        settling, recovering, power_down_request};
    wire rd_ctrl = (ARADDR == daoc_pkg::CTRL_ADDR);
    wire rd_stat = (ARADDR == daoc_pkg::STATUS_ADDR);
    wire rd_cnt = (ARADDR == daoc_pkg::COUNT_ADDR);
    wire [daoc_pkg::DATA_W-1:0] rd_word =
        rd_ctrl ? {{(daoc_pkg::DATA_W - daoc_pkg::CTRL_W){1'b0}}, ctrl_reg} :
        rd_stat ? status_word :
        rd_cnt ? pair_count_reg : '0;

    // one read at a time, answered the cycle after the address
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= daoc_pkg::RESP_OKAY;
        end else if (ar_take) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= (rd_ctrl | rd_stat | rd_cnt) ?
                daoc_pkg::RESP_OKAY : daoc_pkg::RESP_SLVERR;
        end else if (rvalid_reg && RREADY) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // sample buffer
    // ------------------------------------------------------------
    logic buf_valid;
    logic [daoc_pkg::PAIR_W-1:0] buf_data;
    logic buf_ready;
    daoc_pkg::daoc_ost_e ost_reg;  // output sequencer
    logic [daoc_pkg::WORD_W-1:0] held_b_reg;  // b word waiting for the shared bus

    // drained independently of the output enables
    assign buf_ready = (ost_reg == daoc_pkg::OST_PAIR) & ~power_down_request;
    wire pop = buf_valid & buf_ready;
    wire [daoc_pkg::WORD_W-1:0] raw_a = buf_data[daoc_pkg::PAIR_W-1:daoc_pkg::WORD_W];
    wire [daoc_pkg::WORD_W-1:0] raw_b = buf_data[daoc_pkg::WORD_W-1:0];
    // two's complement is offset binary with the top bit flipped
    wire [daoc_pkg::WORD_W-1:0] fmt_a = {raw_a[daoc_pkg::WORD_W-1] ^ twos_mode,
        raw_a[daoc_pkg::WORD_W-2:0]};
    wire [daoc_pkg::WORD_W-1:0] fmt_b = {raw_b[daoc_pkg::WORD_W-1] ^ twos_mode,
        raw_b[daoc_pkg::WORD_W-2:0]};
    // indicator high sits on bit 0 of bus b
    wire [daoc_pkg::WORD_W-1:0] ind_a = {{(daoc_pkg::WORD_W - 1){1'b0}}, 1'b1};

    // power-down flushes the pipeline and drops arriving samples
    daoc_fifo2 #(
        .WIDTH(daoc_pkg::PAIR_W),
        .DEPTH(daoc_pkg::BUF_DEPTH)
    ) u_buf (
        .clk(MCLK),
        .srst(SRST),
        .flush(power_down_request),
        .in_valid(SAMPLE_VALID),
        .in_data({SAMPLE_A, SAMPLE_B}),
        .in_ready(SAMPLE_READY),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(buf_ready)
    );

    // ------------------------------------------------------------
    // output stage
    // ------------------------------------------------------------
    logic [daoc_pkg::WORD_W-1:0] bus_a_reg;  // bus a pins
    logic [daoc_pkg::WORD_W-1:0] bus_b_reg;  // bus b pins, indicator on bit 0
    logic oe_a_reg;
    logic oe_b_reg;

    // words and indicator change on the same edge
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            bus_a_reg <= '0;
            bus_b_reg <= '0;
            held_b_reg <= '0;
            ost_reg <= daoc_pkg::OST_PAIR;
        end else if (power_down_request) begin
            // pins carry zeros, pending half discarded
            bus_a_reg <= '0;
            bus_b_reg <= '0;
            ost_reg <= daoc_pkg::OST_PAIR;
        end else begin
            case (ost_reg)
                daoc_pkg::OST_PAIR: begin
                    if (pop && mux_mode) begin
                        // a word first, indicator high
                        bus_a_reg <= fmt_a;
                        bus_b_reg <= ind_a;
                        held_b_reg <= fmt_b;
                        ost_reg <= daoc_pkg::OST_B;
                    end else if (pop) begin
                        // each channel on its own bus
                        bus_a_reg <= fmt_a;
                        bus_b_reg <= fmt_b;
                    end
                end
                daoc_pkg::OST_B: begin
                    // b word second, indicator low
                    bus_a_reg <= held_b_reg;
                    bus_b_reg <= '0;
                    ost_reg <= daoc_pkg::OST_PAIR;
                end
                default: begin
                    ost_reg <= daoc_pkg::OST_PAIR;
                end
            endcase
        end
    end

    // pin enables follow the disable bits only
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            oe_a_reg <= 1'b0;
            oe_b_reg <= 1'b0;
        end else begin
            oe_a_reg <= ~out_disable_chan_a;
            oe_b_reg <= ~out_disable_chan_b;
        end
    end

    // pairs delivered, for software monitoring
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pair_count_reg <= '0;
        end else if (pop) begin
            pair_count_reg <= pair_count_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // power and selector side effects
    // ------------------------------------------------------------
    logic pd_reg;
    logic stab_reg;
    logic suspect_reg;

    // recharge time reloads while powered down, runs out after
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            recover_cnt_reg <= '0;
        end else if (power_down_request) begin
            recover_cnt_reg <= daoc_pkg::RECOVER_W'(PD_EXIT_CYCLES);
        end else if (recovering) begin
            recover_cnt_reg <= recover_cnt_reg - 1'b1;
        end
    end

    // selector change marks a few words untrustworthy
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            settle_cnt_reg <= '0;
        end else if (fmt_changed) begin
            settle_cnt_reg <= daoc_pkg::SETTLE_W'(daoc_pkg::FMT_SETTLE_CYCLES);
        end else if (settling) begin
            settle_cnt_reg <= settle_cnt_reg - 1'b1;
        end
    end

    // analog controls and receiver hint
    always_ff @(posedge MCLK) begin
        if (SRST) begin
            pd_reg <= 1'b0;
            stab_reg <= 1'b0;
            suspect_reg <= 1'b0;
        end else begin
            pd_reg <= power_down_request;
            stab_reg <= stab_mode;
            suspect_reg <= power_down_request | recovering | settling;
        end
    end

    // ------------------------------------------------------------
    // output connections
    // ------------------------------------------------------------
    assign AWREADY = awready_reg;
    assign WREADY = wready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    assign CHAN_A_SHARED_BUS = bus_a_reg;
    assign CHAN_B_BUS = bus_b_reg;
    assign CHAN_A_OE = oe_a_reg;
    assign CHAN_B_OE = oe_b_reg;
    assign POWER_DOWN = pd_reg;
    assign STABILIZER_ON = stab_reg;
    assign DATA_SUSPECT = suspect_reg;
endmodule : daoc_top

`default_nettype wire

// *** testbench/daoc_checker.sv ***
/* port checker for daoc_top: register handshake, power-down hints.
   assumes it is bound to daoc_top. */
`default_nettype none
module daoc_checker #(
    parameter int PD_EXIT_CYCLES = 20
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic POWER_DOWN,
    input wire logic DATA_SUSPECT
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    // both write halves taken together
    sequence s_wr_take; AWVALID && AWREADY && WVALID && WREADY; endsequence
    // recharge hint held after power-down ends
    sequence s_recov; DATA_SUSPECT [*8]; endsequence
    property p_b_after; s_wr_take |-> ##[1:2] BVALID; endproperty
    a_b_after: assert property (p_b_after) else $error("write response late");
    property p_b_done; BVALID && BREADY |=> !BVALID && AWREADY && WREADY; endproperty
    a_b_done: assert property (p_b_done) else $error("write channel not freed");
    property p_b_busy; BVALID |-> !AWREADY && !WREADY; endproperty
    a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
    property p_r_after; ARVALID && ARREADY |=> RVALID; endproperty
    a_r_after: assert property (p_r_after) else $error("read data late");
    property p_r_done; RVALID && RREADY |=> !RVALID && ARREADY; endproperty
    a_r_done: assert property (p_r_done) else $error("read channel not freed");
    property p_r_busy; RVALID |-> !ARREADY; endproperty
    a_r_busy: assert property (p_r_busy) else $error("read taken while busy");
    property p_pd_sus; POWER_DOWN |-> DATA_SUSPECT; endproperty
    a_pd_sus: assert property (p_pd_sus) else $error("words trusted in power-down");
    property p_recov; $fell(POWER_DOWN) |-> s_recov; endproperty
    a_recov: assert property (p_recov) else $error("recovery hint too short");
endmodule : daoc_checker
bind daoc_top daoc_checker #(.PD_EXIT_CYCLES(PD_EXIT_CYCLES)) i_chk (.MCLK, .SRST,
    .AWVALID, .AWREADY, .WVALID, .WREADY, .BVALID, .BREADY, .ARVALID, .ARREADY,
    .RVALID, .RREADY, .POWER_DOWN, .DATA_SUSPECT);
`default_nettype wire

// *** testbench/daoc_rx_model.sv ***
/* receiving logic model: splits the shared bus by the channel indicator.
   assumes one clock shared with the converter block. */
`default_nettype none
module daoc_rx_model (
    input wire logic clk,
    input wire logic shared,
    input wire logic oe,
    input wire logic [daoc_pkg::WORD_W-1:0] bus_a,
    input wire logic ind
);
    timeunit 1ns;
    timeprecision 1ns;
    logic ind_q = 1'b0; // indicator delayed one cycle
    logic [daoc_pkg::WORD_W-1:0] qa[$]; // channel a words
    logic [daoc_pkg::WORD_W-1:0] qb[$]; // channel b words
    // latch on a delayed indicator change, never on its own edge
    always @(posedge clk) begin
        ind_q <= ind;
        if (shared && oe && ind != ind_q) begin
            if (ind) begin
                qa.push_back(bus_a);
            end else begin
                qb.push_back(bus_a);
            end
        end
    end
endmodule : daoc_rx_model
`default_nettype wire

// *** testbench/tb_dual_adc_output_control.sv ***
/* bench for daoc_top: register tasks, sample pushes, receiver model.
   assumes design files and the checker are compiled first. */
`default_nettype none
module tb_dual_adc_output_control;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PDX = 20; // short recharge count
    logic MCLK = '0, SRST = '1, AWVALID = '0, WVALID = '0, BREADY = '0, ARVALID = '0;
    logic RREADY = '0, SAMPLE_VALID = '0, shared = '0;
    logic [3:0] AWADDR = '0, ARADDR = '0, WSTRB = '0, strb = 4'hf; // byte enables per write
    logic [31:0] WDATA = '0, RDATA;
    logic [11:0] SAMPLE_A = '0, SAMPLE_B = '0, CHAN_A_SHARED_BUS, CHAN_B_BUS;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID, SAMPLE_READY, CHAN_A_OE, CHAN_B_OE;
    logic POWER_DOWN, STABILIZER_ON, DATA_SUSPECT;
    logic [1:0] BRESP, RRESP;
    int failures = 0, cmp_count = 0, cyc = 0;
    always #5 MCLK = ~MCLK;
    daoc_top #(.PD_EXIT_CYCLES(PDX)) i_dut (.MCLK, .SRST, .AWVALID, .AWREADY, .AWADDR,
        .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY,
        .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP, .SAMPLE_VALID, .SAMPLE_READY, .SAMPLE_A,
        .SAMPLE_B, .CHAN_A_SHARED_BUS, .CHAN_A_OE, .CHAN_B_BUS, .CHAN_B_OE, .POWER_DOWN,
        .STABILIZER_ON, .DATA_SUSPECT);
    daoc_rx_model i_rx (.clk(MCLK), .shared(shared), .oe(CHAN_A_OE),
        .bus_a(CHAN_A_SHARED_BUS), .ind(CHAN_B_BUS[0]));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic final_report();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    // bus write, both halves offered together
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge MCLK);
        AWADDR <= a;
        WDATA <= d;
        WSTRB <= strb;
        AWVALID <= 1'b1;
        WVALID <= 1'b1;
        BREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            if (AWREADY) AWVALID <= 1'b0;
            if (WREADY) WVALID <= 1'b0;
        end while (BVALID !== 1'b1);
        BREADY <= 1'b0;
        chk(BRESP, er);
    endtask : wr
    task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge MCLK);
        ARADDR <= a;
        ARVALID <= 1'b1;
        RREADY <= 1'b1;
        do begin
            @(posedge MCLK);
            if (ARREADY) ARVALID <= 1'b0;
        end while (RVALID !== 1'b1);
        RREADY <= 1'b0;
        chk(RDATA, ed);
        chk(RRESP, er);
    endtask : rd
    task automatic push(input logic [11:0] a, input logic [11:0] b);
        @(posedge MCLK);
        SAMPLE_A <= a;
        SAMPLE_B <= b;
        SAMPLE_VALID <= 1'b1;
        do @(posedge MCLK); while (SAMPLE_READY !== 1'b1);
        SAMPLE_VALID <= 1'b0;
    endtask : push
    // hang guard
    always @(posedge MCLK) begin
        cyc++;
        if (cyc == 4000) begin
            failures++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge MCLK);
        SRST <= 1'b0;
        rd(4'h0, 32'h18, 2'h0);
        rd(4'h4, 32'h0, 2'h0);
        rd(4'hc, 32'h0, 2'h2);
        wr(4'hc, 32'h1, 2'h2);
        wr(4'h4, 32'h1f, 2'h0);
        // control write with its low byte disabled leaves control untouched
        strb = 4'he;
        wr(4'h0, 32'h0, 2'h0);
        strb = 4'hf;
        rd(4'h0, 32'h18, 2'h0);
        rd(4'h4, 32'h0, 2'h0);
        $display("test registers done");
        for (int v = 0; v < 4; v++) begin
            wr(4'h0, 32'(v << 3), 2'h0);
            @(posedge MCLK);
            chk(DATA_SUSPECT, 1);
            repeat (7) @(posedge MCLK);
            chk(STABILIZER_ON, v < 2);
            rd(4'h4, {27'h0, ~v[0], ~v[1], 3'h0}, 2'h0);
            push(12'h800, 12'h123);
            repeat (4) @(posedge MCLK);
            chk(CHAN_A_SHARED_BUS, v[0] ? 12'h800 : 12'h000);
            chk(CHAN_B_BUS, v[0] ? 12'h123 : 12'h923);
        end
        $display("test selector done");
        wr(4'h0, 32'h19, 2'h0);
        push(12'h1, 12'h2);
        repeat (3) @(posedge MCLK);
        chk(CHAN_A_OE, 0);
        chk(CHAN_B_OE, 1);
        rd(4'h8, 32'h5, 2'h0);
        wr(4'h0, 32'h1a, 2'h0);
        repeat (2) @(posedge MCLK);
        chk(CHAN_A_OE, 1);
        chk(CHAN_B_OE, 0);
        $display("test enables done");
        wr(4'h0, 32'h38, 2'h0);
        shared <= 1'b1;
        for (int i = 0; i < 3; i++) push(12'h100 + 12'(i), 12'h200 + 12'(i));
        repeat (8) @(posedge MCLK);
        chk(CHAN_B_BUS[11:1], 0);
        chk(i_rx.qa.size(), 3);
        for (int i = 0; i < 3; i++) begin
            chk(i_rx.qa[i], 32'h100 + i);
            chk(i_rx.qb[i], 32'h200 + i);
        end
        shared <= 1'b0;
        $display("test shared bus done");
        wr(4'h0, 32'h1c, 2'h0);
        push(12'h5, 12'h6);
        repeat (3) @(posedge MCLK);
        chk(POWER_DOWN, 1);
        chk(DATA_SUSPECT, 1);
        chk(CHAN_A_SHARED_BUS, 0);
        wr(4'h0, 32'h18, 2'h0);
        repeat (PDX - 8) @(posedge MCLK);
        chk(DATA_SUSPECT, 1);
        repeat (16) @(posedge MCLK);
        chk(DATA_SUSPECT, 0);
        $display("test power-down done");
        final_report();
    end
endmodule : tb_dual_adc_output_control
`default_nettype wire
